// ### design/sfwp_top.sv
// serial flash write protection: latch, range guard, freeze, sector locks, otp locks
// assumes decoded command strobes from a serial front end on clk_sys
// Behaviour
// [RULE_01] one volatile lock byte per sector, reset FFh; 00h protects, FFh frees
// [RULE_02] 1024-byte one-time space, 32 regions of 32 bytes, each lockable
// [RULE_03] one-time reads use fast read; beyond 1 KB data is undefined
// [RULE_04] one-time space may be programmed repeatedly, never erased
// [RULE_05] check bits made on first program per 16 bytes; re-program disables them
// [RULE_06] out-of-range one-time program is ignored and the write latch stays set
// [RULE_07] one-time program while frozen fails and sets the program-error flag
// [RULE_08] each lock byte guards 8 regions; bit 0 at 0x10 guards lock bytes
// [RULE_09] host issues write enable before any nonvolatile change
// [RULE_10] write latch cleared at reset and after listed commands complete
// [RULE_11] three guard bits select none, 1/64 up to 1/2, or all
// [RULE_12] origin bit 0 protects from top, 1 from bottom
// [RULE_13] sector protection is the OR of range and sector schemes
// [RULE_14] software should use one protection scheme, not both
// [RULE_15] freeze locks guard and origin bits; only power-on clears it
// [RULE_16] guard writes while frozen are dropped silently
// [RULE_17] pin low with write-disable flag set blocks status and config writes
// [RULE_18] sector rejects program or erase if either lock bit is 0
// [RULE_19] gate bit 0 blocks all program and erase of nonvolatile locks
// [RULE_20] persistent mode: gate set at reset, cleared by command only
// [RULE_21] password mode: gate clear at reset, set on 64-bit match
// [RULE_22] mode chosen by one-time config bits; programming fixes it
// [RULE_23] mode bits 11 none, 10 persistent, 01 password, 00 illegal
// [RULE_24] nonvolatile lock program or erase fails while gate is 0
// [RULE_25] all protection sources checked when the command is accepted
`timescale 1ns/100ps
module sfwp_top #(
	parameter logic [63:0] HIDDEN_PWD = 64'hffff_ffff_ffff_ffff
) (
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	input  wire logic                         por_n,
	input  wire logic                         write_guard_n,
	input  wire logic                         req_valid,
	input  wire sfwp_pkg::sfwp_req_s          req,
	output logic      [7:0]                   status_reg_one,
	output logic      [7:0]                   config_reg,
	output logic      [1:0]                   guard_config_reg,
	output logic                              lock_array_gate,
	output logic      [7:0]                   volatile_lock_access,
	output logic      [sfwp_pkg::SECTORS-1:0] sector_protected,
	output logic                              op_go,
	output logic                              op_fail,
	output logic                              otp_ecc_on
);
	typedef struct packed {
		logic                                 wlatch;
		logic [2:0]                           guard;
		logic                                 wdis;
		logic                                 perr;
		logic                                 origin;
		logic                                 freeze;
		logic [1:0]                           mode;
		logic                                 gate;
		logic [sfwp_pkg::SECTORS-1:0]         vlock;
		logic [sfwp_pkg::SECTORS-1:0]         nvlock;
		logic [sfwp_pkg::OTP_REGIONS-1:0]     otp_lock;
		logic [sfwp_pkg::OTP_PORTIONS-1:0]    otp_written;
		logic [sfwp_pkg::OTP_PORTIONS-1:0]    otp_ecc_off;
		logic [7:0]                           vl_rd;
		logic                                 go;
		logic                                 fail;
		logic                                 ecc_on;
		logic [sfwp_pkg::SECTORS-1:0]         prot;
		logic                                 pwr_seen;
	} sfwp_state_s;

	sfwp_state_s st_r;
	sfwp_state_s st_nxt;
	logic [sfwp_pkg::SECTORS-1:0] range_prot;

	sfwp_range u_range (
		.guard  (st_r.guard),
		.origin (st_r.origin),
		.prot   (range_prot)
	);

	logic                   sec_prot;
	logic                   regs_locked;
	logic                   otp_in_range;
	logic [4:0]             otp_region;
	logic [5:0]             otp_portion;
	logic                   otp_region_locked;
	logic                   is_lock_byte;
	logic                   lock_bytes_locked;

	always_comb begin
		// [RULE_13] range OR sector locks
		// [RULE_18] either lock bit 0 protects
		sec_prot = range_prot[req.sector] | ~st_r.vlock[req.sector]
			| ~st_r.nvlock[req.sector];
		// [RULE_17] pin and flag lock registers
		regs_locked = ~write_guard_n & st_r.wdis;
		// [RULE_03] valid one-time addresses only
		otp_in_range = req.addr < 24'(sfwp_pkg::OTP_BYTES);
		otp_region = req.addr[sfwp_pkg::OTP_REG_SH +: 5];
		otp_portion = req.addr[sfwp_pkg::OTP_ECC_SH +: 6];
		otp_region_locked = ~st_r.otp_lock[otp_region];
		// [RULE_08] bit 0 at 0x10 guards lock bytes
		is_lock_byte = (otp_region == 5'h00) && (req.addr[4:0] >= 5'(sfwp_pkg::LOCK_BASE));
		lock_bytes_locked = ~st_r.otp_lock[0];
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.go = 1'b0;
		st_nxt.fail = 1'b0;
		st_nxt.prot = range_prot | ~st_r.vlock | ~st_r.nvlock;
		st_nxt.ecc_on = ~st_r.otp_ecc_off[otp_portion];
		st_nxt.pwr_seen = 1'b1;
		if (req_valid) begin
			// [RULE_25] checked at acceptance
			case (req.cmd)
				sfwp_pkg::SFWP_WRITE_ENABLE_CMD: begin
					st_nxt.wlatch = 1'b1;
				end
				sfwp_pkg::SFWP_WRITE_DISABLE_CMD: begin
					// [RULE_10] latch cleared on completion
					st_nxt.wlatch = 1'b0;
				end
				sfwp_pkg::SFWP_RESET: begin
					st_nxt.wlatch = 1'b0;
					st_nxt.vlock = '1;
				end
				sfwp_pkg::SFWP_REGWR: begin
					if (st_r.wlatch && !regs_locked) begin
						st_nxt.wdis = req.sr_data[sfwp_pkg::SR_WDIS_BIT];
						// [RULE_15] freeze holds guard and origin
						// [RULE_16] silently dropped when frozen
						if (!st_r.freeze) begin
							st_nxt.guard = req.sr_data[sfwp_pkg::SR_GUARD_LO +: 3];
							st_nxt.origin = req.cfg_data[sfwp_pkg::CFG_ORIGIN_BIT];
						end
						st_nxt.freeze = st_r.freeze | req.cfg_data[sfwp_pkg::CFG_FREEZE_BIT];
						st_nxt.go = 1'b1;
					end else begin
						st_nxt.fail = 1'b1;
					end
					if (st_r.wlatch) begin
						st_nxt.wlatch = 1'b0;
					end
				end
				sfwp_pkg::SFWP_PAGE, sfwp_pkg::SFWP_QPAGE, sfwp_pkg::SFWP_SWIPE: begin
					if (st_r.wlatch && !sec_prot) begin
						st_nxt.go = 1'b1;
					end else begin
						st_nxt.fail = 1'b1;
					end
					st_nxt.wlatch = 1'b0;
				end
				sfwp_pkg::SFWP_AWIPE: begin
					// whole wipe refused if any sector is guarded
					if (st_r.wlatch && !(|st_nxt.prot)) begin
						st_nxt.go = 1'b1;
					end else begin
						st_nxt.fail = 1'b1;
					end
					st_nxt.wlatch = 1'b0;
				end
				sfwp_pkg::SFWP_OTPW: begin
					// [RULE_07] frozen space fails with error
					if (st_r.freeze && st_r.wlatch) begin
						st_nxt.perr = 1'b1;
						st_nxt.fail = 1'b1;
						st_nxt.wlatch = 1'b0;
					// [RULE_06] out of range ignored, latch kept
					end else if (!otp_in_range) begin
						st_nxt.fail = 1'b1;
					end else if (st_r.wlatch) begin
						// [RULE_02] per-region lock
						if (otp_region_locked || (is_lock_byte && lock_bytes_locked)) begin
							st_nxt.fail = 1'b1;
						end else begin
							// [RULE_04] repeat programs allowed
							st_nxt.go = 1'b1;
							if (is_lock_byte && req.addr[4:0] < 5'(sfwp_pkg::LOCK_BASE
								+ sfwp_pkg::LOCK_BYTES)) begin
								st_nxt.otp_lock[{req.addr[1:0], 3'h0} +: 8] =
									st_r.otp_lock[{req.addr[1:0], 3'h0} +: 8] & req.data;
							end
							// [RULE_05] second write kills check bits
							if (st_r.otp_written[otp_portion]) begin
								st_nxt.otp_ecc_off[otp_portion] = 1'b1;
							end
							st_nxt.otp_written[otp_portion] = 1'b1;
						end
						st_nxt.wlatch = 1'b0;
					end else begin
						st_nxt.fail = 1'b1;
					end
				end
				sfwp_pkg::SFWP_VLWR: begin
					// [RULE_01] volatile byte per sector
					if (st_r.wlatch) begin
						st_nxt.vlock[req.sector] = (req.data == sfwp_pkg::VLOCK_CLEAR) ? 1'b0 : 1'b1;
						st_nxt.go = 1'b1;
						st_nxt.wlatch = 1'b0;
					end else begin
						st_nxt.fail = 1'b1;
					end
				end
				sfwp_pkg::SFWP_NVPROG, sfwp_pkg::SFWP_NVWIPE: begin
					// [RULE_19] gate blocks lock array
					// [RULE_24] fails with bits untouched
					if (st_r.wlatch && st_r.gate) begin
						if (req.cmd == sfwp_pkg::SFWP_NVPROG) begin
							st_nxt.nvlock[req.sector] = 1'b0;
						end else begin
							st_nxt.nvlock = '1;
						end
						st_nxt.go = 1'b1;
					end else begin
						st_nxt.fail = 1'b1;
						st_nxt.perr = st_r.wlatch;
					end
					st_nxt.wlatch = 1'b0;
				end
				sfwp_pkg::SFWP_GATECL: begin
					// [RULE_20] command only closes it
					st_nxt.gate = 1'b0;
					st_nxt.go = 1'b1;
				end
				sfwp_pkg::SFWP_UNLOCK: begin
					// [RULE_21] set only on password match
					if (st_r.mode == sfwp_pkg::MODE_PASSWORD && req.pwd == HIDDEN_PWD) begin
						st_nxt.gate = 1'b1;
						st_nxt.go = 1'b1;
					end else begin
						st_nxt.fail = 1'b1;
					end
				end
				sfwp_pkg::SFWP_MODEPR: begin
					// [RULE_22] fixed once programmed
					// [RULE_23] both bits zero illegal
					if (st_r.wlatch && st_r.mode == sfwp_pkg::MODE_NONE
						&& req.mode_bits != 2'b00) begin
						st_nxt.mode = req.mode_bits;
						st_nxt.go = 1'b1;
					end else begin
						st_nxt.fail = 1'b1;
						st_nxt.perr = st_r.wlatch;
					end
					st_nxt.wlatch = 1'b0;
				end
				default: begin
					st_nxt.go = 1'b0;
				end
			endcase
		end
		st_nxt.vl_rd = st_nxt.vlock[req.sector] ? sfwp_pkg::VLOCK_RESET
			: sfwp_pkg::VLOCK_CLEAR;
		// [RULE_20] gate takes its mode value once after reset
		if (!st_r.pwr_seen) begin
			st_nxt.gate = (st_r.mode != sfwp_pkg::MODE_PASSWORD);
		end
	end

	// one-time config and nonvolatile state survive warm reset; por_n models power-up
	// one process owns the state record, so rst_n leaves nonvolatile fields holding
	always_ff @(posedge clk_sys or negedge por_n or negedge rst_n) begin
		if (!por_n) begin
			st_r.pwr_seen <= 1'b0;
			st_r.wlatch <= 1'b0;
			st_r.vlock <= '1;
			st_r.gate <= 1'b0;
			st_r.go <= 1'b0;
			st_r.fail <= 1'b0;
			st_r.vl_rd <= sfwp_pkg::VLOCK_RESET;
			st_r.prot <= '0;
			st_r.ecc_on <= 1'b1;
			st_r.guard <= 3'h0;
			st_r.wdis <= 1'b0;
			st_r.perr <= 1'b0;
			st_r.origin <= 1'b0;
			st_r.freeze <= 1'b0;
			st_r.mode <= sfwp_pkg::MODE_NONE;
			st_r.nvlock <= '1;
			st_r.otp_lock <= '1;
			st_r.otp_written <= '0;
			st_r.otp_ecc_off <= '0;
		end else if (!rst_n) begin
			st_r.pwr_seen <= 1'b0;
			st_r.wlatch <= 1'b0;
			st_r.vlock <= '1;
			st_r.gate <= 1'b0;
			st_r.go <= 1'b0;
			st_r.fail <= 1'b0;
			st_r.vl_rd <= sfwp_pkg::VLOCK_RESET;
			st_r.prot <= '0;
			st_r.ecc_on <= 1'b1;
		end else begin
			st_r.pwr_seen <= st_nxt.pwr_seen;
			st_r.wlatch <= st_nxt.wlatch;
			st_r.vlock <= st_nxt.vlock;
			st_r.gate <= st_nxt.gate;
			st_r.go <= st_nxt.go;
			st_r.fail <= st_nxt.fail;
			st_r.vl_rd <= st_nxt.vl_rd;
			st_r.prot <= st_nxt.prot;
			st_r.ecc_on <= st_nxt.ecc_on;
			st_r.guard <= st_nxt.guard;
			st_r.wdis <= st_nxt.wdis;
			st_r.perr <= st_nxt.perr;
			st_r.origin <= st_nxt.origin;
			st_r.freeze <= st_nxt.freeze;
			st_r.mode <= st_nxt.mode;
			st_r.nvlock <= st_nxt.nvlock;
			st_r.otp_lock <= st_nxt.otp_lock;
			st_r.otp_written <= st_nxt.otp_written;
			st_r.otp_ecc_off <= st_nxt.otp_ecc_off;
		end
	end

	always_comb begin
		status_reg_one = {st_r.wdis, st_r.perr, 1'b0, st_r.guard, st_r.wlatch, 1'b0};
		config_reg = {2'b00, st_r.origin, 4'h0, st_r.freeze};
		guard_config_reg = st_r.mode;
		lock_array_gate = st_r.gate;
		volatile_lock_access = st_r.vl_rd;
		sector_protected = st_r.prot;
		op_go = st_r.go;
		op_fail = st_r.fail;
		otp_ecc_on = st_r.ecc_on;
	end
endmodule : sfwp_top

// ### design/sfwp_pkg.sv
// package for the serial flash write protection block
// assumes a command decoder outside presents decoded, one-cycle command strobes
package sfwp_pkg;
	localparam int SECTORS      = 64;
	localparam int SEC_W        = 6;
	localparam int ARRAY_KB     = 16384;
	localparam int SECTOR_KB    = ARRAY_KB / SECTORS;
	localparam int OTP_BYTES    = 1024;
	localparam int OTP_AW       = 10;
	localparam int OTP_REGIONS  = 32;
	localparam int OTP_REG_SH   = 5;
	localparam int OTP_ECC_SH   = 4;
	localparam int OTP_PORTIONS = OTP_BYTES / 16;
	localparam int LOCK_BASE    = 16;
	localparam int LOCK_BYTES   = OTP_REGIONS / 8;
	localparam logic [7:0] VLOCK_RESET = 8'hff;
	localparam logic [7:0] VLOCK_CLEAR = 8'h00;
	localparam logic [1:0] MODE_NONE       = 2'b11;
	localparam logic [1:0] MODE_PERSISTENT = 2'b10;
	localparam logic [1:0] MODE_PASSWORD   = 2'b01;
	localparam int CFG_FREEZE_BIT = 0;
	localparam int CFG_ORIGIN_BIT = 5;
	localparam int SR_GUARD_LO    = 2;
	localparam int SR_WDIS_BIT    = 7;
	localparam int SR_PERR_BIT    = 6;
	localparam int SR_WLATCH_BIT  = 1;

	typedef enum logic [3:0] {
		SFWP_NOP    = 4'h0,
		SFWP_WRITE_ENABLE_CMD   = 4'h1,
		SFWP_WRITE_DISABLE_CMD   = 4'h2,
		SFWP_REGWR  = 4'h3,
		SFWP_PAGE   = 4'h4,
		SFWP_QPAGE  = 4'h5,
		SFWP_SWIPE  = 4'h6,
		SFWP_AWIPE  = 4'h7,
		SFWP_OTPW   = 4'h8,
		SFWP_VLWR   = 4'h9,
		SFWP_NVPROG = 4'ha,
		SFWP_NVWIPE = 4'hb,
		SFWP_GATECL = 4'hc,
		SFWP_UNLOCK = 4'hd,
		SFWP_RESET  = 4'he,
		SFWP_MODEPR = 4'hf
	} sfwp_cmd_e;

	typedef struct packed {
		sfwp_cmd_e        cmd;
		logic [SEC_W-1:0] sector;
		logic [23:0]      addr;
		logic [7:0]       data;
		logic [7:0]       sr_data;
		logic [7:0]       cfg_data;
		logic [63:0]      pwd;
		logic [1:0]       mode_bits;
	} sfwp_req_s;
endpackage : sfwp_pkg

// ### design/sfwp_range.sv
// block-range decoder: size code and origin to a per-sector guard vector
// assumes sectors of equal size, array split into SECTORS pieces
`timescale 1ns/100ps
module sfwp_range (
	input  wire logic [2:0]                   guard,
	input  wire logic                         origin,
	output logic      [sfwp_pkg::SECTORS-1:0] prot
);
	logic [6:0] count;
	always_comb begin
		// [RULE_11] size doubling per step
		case (guard)
			3'h0: count = 7'h00;
			3'h7: count = 7'(sfwp_pkg::SECTORS);
			default: count = 7'(sfwp_pkg::SECTORS >> (7 - 32'(guard)));
		endcase
	end
	genvar i;
	generate
		for (i = 0; i < sfwp_pkg::SECTORS; i++) begin : g_sec
			// [RULE_12] top or bottom origin
			assign prot[i] = origin ? (7'(i) < count) : (7'(sfwp_pkg::SECTORS - 1 - i) < count);
		end
	endgenerate
endmodule : sfwp_range

// ### test/sfwp_host.sv
// host model: drives one decoded request per call, preceded by a write enable request when asked
// assumes requests are taken on the rising clk_sys edge
`timescale 1ns/100ps
module sfwp_host (
	input  wire logic                clk_sys,
	output logic                     req_valid,
	output sfwp_pkg::sfwp_req_s      req
);
	initial begin
		req_valid = 1'h0;
		req = '0;
	end
	task automatic send(input sfwp_pkg::sfwp_req_s r, input logic write_enable_cmd);
		if (write_enable_cmd) begin
			@(posedge clk_sys) #1;
			req_valid = 1'h1;
			req = '0;
			req.cmd = sfwp_pkg::SFWP_WRITE_ENABLE_CMD;
		end
		// otp addresses passed through unchecked; caller may send out-of-range ones
		@(posedge clk_sys) #1;
		req_valid = 1'h1;
		req = r;
		@(posedge clk_sys) #1;
		req_valid = 1'h0;
		// released lines show inverse, not a stale copy
		req = ~r;
	endtask : send
endmodule : sfwp_host

// ### test/sfwp_top_chk.sv
// checker on the ports of sfwp_top
// assumes bind from the bench top file
`timescale 1ns/100ps
module sfwp_chk (
	input wire logic                         clk_sys,
	input wire logic                         rst_n,
	input wire logic                         por_n,
	input wire logic                         write_guard_n,
	input wire logic                         req_valid,
	input wire sfwp_pkg::sfwp_req_s          req,
	input wire logic [7:0]                   status_reg_one,
	input wire logic [7:0]                   config_reg,
	input wire logic [1:0]                   guard_config_reg,
	input wire logic                         lock_array_gate,
	input wire logic [sfwp_pkg::SECTORS-1:0] sector_protected,
	input wire logic                         op_go,
	input wire logic                         op_fail
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n || !por_n);
	answer_cause_a: assert property (
		(op_go || op_fail) |-> $past(req_valid) && !(op_go && op_fail)
	) else $error("answer without request");
	latch_set_a: assert property (
		req_valid && req.cmd == sfwp_pkg::SFWP_WRITE_ENABLE_CMD |=> status_reg_one[1]
	) else $error("write latch not set");
	no_latch_a: assert property (
		req_valid && !status_reg_one[1] && req.cmd inside {sfwp_pkg::SFWP_PAGE,
		sfwp_pkg::SFWP_SWIPE, sfwp_pkg::SFWP_OTPW} |=> op_fail && !op_go
	) else $error("write without latch done");
	latch_clear_a: assert property (
		op_go && $past(req.cmd) inside {sfwp_pkg::SFWP_PAGE, sfwp_pkg::SFWP_QPAGE,
		sfwp_pkg::SFWP_WRITE_DISABLE_CMD, sfwp_pkg::SFWP_REGWR} |-> !status_reg_one[1]
	) else $error("write latch kept");
	freeze_hold_a: assert property (
		config_reg[0] |=> $stable(status_reg_one[4:2]) && $stable(config_reg[5])
	) else $error("guard changed while frozen");
	freeze_keep_a: assert property (
		config_reg[0] |=> config_reg[0]
	) else $error("freeze cleared");
	frozen_otp_a: assert property (
		req_valid && config_reg[0] && req.cmd == sfwp_pkg::SFWP_OTPW
		|=> op_fail && status_reg_one[6]
	) else $error("otp program while frozen");
	pin_lock_a: assert property (
		req_valid && req.cmd == sfwp_pkg::SFWP_REGWR && !write_guard_n && status_reg_one[7]
		|=> op_fail && $stable(config_reg)
	) else $error("register write under pin lock");
	gate_shut_a: assert property (
		req_valid && !lock_array_gate && req.cmd inside {sfwp_pkg::SFWP_NVPROG,
		sfwp_pkg::SFWP_NVWIPE} |=> op_fail
	) else $error("lock bits changed with gate shut");
	gate_stay_a: assert property (
		$past(rst_n) && !lock_array_gate && guard_config_reg != 2'h1 |=> !lock_array_gate
	) else $error("gate reopened by command");
	all_guard_a: assert property (
		status_reg_one[4:2] == 3'h7 |=> &sector_protected
	) else $error("full guard not applied");
endmodule : sfwp_chk

// ### test/test_serial_flash_write_protection.sv
// bench for sfwp_top: one task per scenario
// assumes sfwp_host and sfwp_chk compiled first
`timescale 1ns/100ps
module test_serial_flash_write_protection;
	localparam logic [1:0] GO = 2'h2;
	localparam logic [1:0] NG = 2'h1;
	logic                clk_sys = 1'h0;
	logic                rst_n = 1'h0;
	logic                por_n = 1'h0;
	logic                wg_n = 1'h1;
	logic                req_valid;
	sfwp_pkg::sfwp_req_s req;
	logic [7:0]          sr, cfg, vla;
	logic [1:0]          gcr;
	logic                gate, go, fail, ecc;
	logic [63:0]         prot;
	int                  fails = 0;
	int                  comparisons = 0;
	int                  cycles = 0;
	always #4 clk_sys = ~clk_sys;
	sfwp_top #(.HIDDEN_PWD(64'h5a5a_5a5a_5a5a_5a5a)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.por_n(por_n), .write_guard_n(wg_n), .req_valid(req_valid), .req(req),
		.status_reg_one(sr), .config_reg(cfg), .guard_config_reg(gcr), .lock_array_gate(gate),
		.volatile_lock_access(vla), .sector_protected(prot), .op_go(go), .op_fail(fail),
		.otp_ecc_on(ecc));
	sfwp_host host (.clk_sys(clk_sys), .req_valid(req_valid), .req(req));
	task automatic summarize;
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// hang guard well above the run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			summarize();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic reset(input logic power);
		@(posedge clk_sys) #1;
		rst_n = 1'h0;
		if (power) por_n = 1'h0;
		repeat (3) @(posedge clk_sys);
		#1;
		rst_n = 1'h1;
		por_n = 1'h1;
	endtask : reset
	// a doubles as register-write config byte, d as status byte, mode and password
	task automatic cmd(input sfwp_pkg::sfwp_cmd_e c, input logic [5:0] s,
		input logic [23:0] a, input logic [7:0] d, input logic w);
		sfwp_pkg::sfwp_req_s r;
		r = '{c, s, a, d, d, a[7:0], {8{d}}, d[1:0]};
		host.send(r, w);
	endtask : cmd
	task automatic t_reset;
		cmd(sfwp_pkg::SFWP_NOP, 6'h09, 24'h0, 8'h0, 1'h0);
		chk(vla, 8'hff);
		chk(sr[1], 1'h0);
		chk(gate, 1'h1);
		chk(gcr, 2'h3);
	endtask : t_reset
	task automatic t_latch;
		sfwp_pkg::sfwp_cmd_e k[4];
		k = '{sfwp_pkg::SFWP_PAGE, sfwp_pkg::SFWP_QPAGE, sfwp_pkg::SFWP_SWIPE,
			sfwp_pkg::SFWP_AWIPE};
		for (int i = 0; i < 4; i++) begin
			cmd(k[i], 6'h05, 24'h0, 8'h0, 1'h0);
			chk({go, fail}, NG);
			cmd(k[i], 6'h05, 24'h0, 8'h0, 1'h1);
			chk({go, fail, sr[1]}, {GO, 1'h0});
		end
		cmd(sfwp_pkg::SFWP_WRITE_DISABLE_CMD, 6'h0, 24'h0, 8'h0, 1'h1);
		chk(sr[1], 1'h0);
	endtask : t_latch
	task automatic t_range;
		int n;
		logic [63:0] m;
		for (int o = 0; o < 2; o++) begin
			for (int g = 0; g < 8; g++) begin
				n = (g == 0) ? 0 : (g == 7) ? 64 : 1 << (g - 1);
				m = (n == 64) ? '1 : ((64'h1 << n) - 64'h1);
				if (o == 0) m = m << (64 - n);
				cmd(sfwp_pkg::SFWP_REGWR, 6'h0, {18'h0, o[0], 5'h0}, {3'h0, g[2:0], 2'h0}, 1'h1);
				@(posedge clk_sys) #1;
				chk(prot, m);
			end
		end
	endtask : t_range
	task automatic t_vlock;
		// both schemes at once only here, undone by the register write and reset below
		cmd(sfwp_pkg::SFWP_REGWR, 6'h0, 24'h0, 8'h04, 1'h1);
		cmd(sfwp_pkg::SFWP_VLWR, 6'h03, 24'h0, 8'h00, 1'h1);
		cmd(sfwp_pkg::SFWP_NOP, 6'h03, 24'h0, 8'h0, 1'h0);
		chk(vla, 8'h00);
		chk(prot, 64'h8000_0000_0000_0008);
		cmd(sfwp_pkg::SFWP_PAGE, 6'h03, 24'h0, 8'h0, 1'h1);
		chk({go, fail}, NG);
		cmd(sfwp_pkg::SFWP_REGWR, 6'h0, 24'h0, 8'h00, 1'h1);
		cmd(sfwp_pkg::SFWP_RESET, 6'h03, 24'h0, 8'h0, 1'h1);
		chk({vla, sr[1]}, {8'hff, 1'h0});
	endtask : t_vlock
	task automatic t_gate;
		cmd(sfwp_pkg::SFWP_NVPROG, 6'h07, 24'h0, 8'h0, 1'h1);
		cmd(sfwp_pkg::SFWP_GATECL, 6'h0, 24'h0, 8'h0, 1'h0);
		chk({prot[7], gate}, 2'h2);
		cmd(sfwp_pkg::SFWP_NVWIPE, 6'h0, 24'h0, 8'h0, 1'h1);
		chk({go, fail}, NG);
		reset(1'h0);
		cmd(sfwp_pkg::SFWP_NVWIPE, 6'h0, 24'h0, 8'h0, 1'h1);
		@(posedge clk_sys) #1;
		chk({prot[7], gate}, 2'h1);
	endtask : t_gate
	task automatic t_otp;
		cmd(sfwp_pkg::SFWP_OTPW, 6'h0, 24'h00_0400, 8'h0, 1'h1);
		chk({go, fail, sr[1]}, {NG, 1'h1});
		cmd(sfwp_pkg::SFWP_OTPW, 6'h0, 24'h20, 8'h0, 1'h1);
		cmd(sfwp_pkg::SFWP_NOP, 6'h0, 24'h20, 8'h0, 1'h0);
		chk(ecc, 1'h1);
		cmd(sfwp_pkg::SFWP_OTPW, 6'h0, 24'h21, 8'h0, 1'h1);
		chk({go, fail}, GO);
		cmd(sfwp_pkg::SFWP_NOP, 6'h0, 24'h20, 8'h0, 1'h0);
		chk(ecc, 1'h0);
		cmd(sfwp_pkg::SFWP_OTPW, 6'h0, 24'h10, 8'hfe, 1'h1);
		cmd(sfwp_pkg::SFWP_OTPW, 6'h0, 24'h05, 8'h0, 1'h1);
		chk({go, fail}, NG);
		cmd(sfwp_pkg::SFWP_OTPW, 6'h0, 24'h11, 8'h0, 1'h1);
		chk({go, fail}, NG);
		cmd(sfwp_pkg::SFWP_OTPW, 6'h0, 24'h40, 8'h0, 1'h1);
		chk({go, fail}, GO);
	endtask : t_otp
	task automatic t_freeze;
		cmd(sfwp_pkg::SFWP_REGWR, 6'h0, 24'h01, 8'h08, 1'h1);
		cmd(sfwp_pkg::SFWP_REGWR, 6'h0, 24'h01, 8'h00, 1'h1);
		chk({go, fail, sr[4:2]}, {GO, 3'h2});
		cmd(sfwp_pkg::SFWP_OTPW, 6'h0, 24'h60, 8'h0, 1'h1);
		chk({go, fail, sr[6]}, {NG, 1'h1});
		reset(1'h0);
		chk(cfg[0], 1'h1);
		reset(1'h1);
		chk(cfg[0], 1'h0);
	endtask : t_freeze
	task automatic t_pin;
		cmd(sfwp_pkg::SFWP_REGWR, 6'h0, 24'h0, 8'h84, 1'h1);
		wg_n = 1'h0;
		cmd(sfwp_pkg::SFWP_REGWR, 6'h0, 24'h0, 8'h00, 1'h1);
		chk({go, fail, sr[4:2]}, {NG, 3'h1});
		wg_n = 1'h1;
		cmd(sfwp_pkg::SFWP_REGWR, 6'h0, 24'h0, 8'h00, 1'h1);
		chk({go, fail, sr[4:2]}, {GO, 3'h0});
	endtask : t_pin
	task automatic t_pwd;
		cmd(sfwp_pkg::SFWP_MODEPR, 6'h0, 24'h0, 8'h00, 1'h1);
		chk({go, fail, gcr}, {NG, 2'h3});
		cmd(sfwp_pkg::SFWP_MODEPR, 6'h0, 24'h0, 8'h01, 1'h1);
		reset(1'h0);
		cmd(sfwp_pkg::SFWP_UNLOCK, 6'h0, 24'h0, 8'h00, 1'h0);
		chk({gcr, gate}, 3'h2);
		cmd(sfwp_pkg::SFWP_UNLOCK, 6'h0, 24'h0, 8'h5a, 1'h0);
		chk(gate, 1'h1);
		cmd(sfwp_pkg::SFWP_MODEPR, 6'h0, 24'h0, 8'h02, 1'h1);
		cmd(sfwp_pkg::SFWP_GATECL, 6'h0, 24'h0, 8'h0, 1'h0);
		chk({gcr, gate}, 3'h2);
	endtask : t_pwd
	initial begin
		reset(1'h1);
		t_reset();
		t_latch();
		t_range();
		t_vlock();
		t_gate();
		t_otp();
		t_freeze();
		t_pin();
		t_pwd();
		summarize();
	end
endmodule : test_serial_flash_write_protection
bind sfwp_top sfwp_chk chk (.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
	.write_guard_n(write_guard_n), .req_valid(req_valid), .req(req),
	.status_reg_one(status_reg_one), .config_reg(config_reg),
	.guard_config_reg(guard_config_reg), .lock_array_gate(lock_array_gate),
	.sector_protected(sector_protected), .op_go(op_go), .op_fail(op_fail));
